// ### include/afc_pkg.sv
// package of offsets, fields, reset values and types for the adc fifo control block
package afc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_CHAN     = 8'h04;
  localparam logic [7:0] OFF_RES_HI   = 8'h08;
  localparam logic [7:0] OFF_RES_LO   = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int DEPTH_LSB   = 0;
  localparam int CMB_BIT     = 5;
  localparam int SCAN_BIT    = 6;
  localparam int CHAN_LSB    = 0;
  localparam int CONT_BIT    = 5;
  localparam int CMPEN_BIT   = 6;
  localparam int CONVERSION_COMPLETE_FLAG_BIT    = 7;
  localparam int RES_HI_LSB  = 8;
  localparam int IRQ_CONVERSION_COMPLETE_FLAG    = 0;
  localparam int IRQ_OVF     = 1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and sizes
  localparam logic [2:0] DEPTH_RST   = 3'h0;
  localparam logic [4:0] CHAN_OFF    = 5'h1f;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam int         MAX_LEVELS  = 8;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic       scan;
    logic       cmb;
    logic [2:0] depth;
  } afc_ctrl_t;

  typedef struct packed {
    logic       cmp_en;
    logic       cont;
    logic [4:0] chan;
  } afc_sc1_t;

  typedef struct packed {
    logic       start;
    logic [4:0] chan;
  } afc_conv_req_t;

  typedef struct packed {
    logic        done;
    logic [11:0] result;
    logic        cmp_hit;
  } afc_conv_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FILL,
    ST_START,
    ST_WAIT
  } afc_state_t;

endpackage

// ### rtl/afc_fifo_ctrl.sv
// apb-controlled channel/result fifo, scan and compare-combine control of the adc
`timescale 1ns/10ps
`default_nettype none
// How it works
// - bits 7 and 4-3 of the fifo control register always read as zero.
// - a depth field of 000 keeps the fifo off and runs one channel, one result.
// - a nonzero depth field turns the fifo on with depth field plus one entries.
// - in fifo mode channel writes push the channel fifo and low-half result reads pop results.
// - in fifo mode no conversion starts until the channel fifo holds the depth.
// - in fifo mode the complete flag rises only once the whole set has converted.
// - scan with the fifo on converts the first queued channel until results are full.
// - scan plus continuous starts the next conversion on that channel once complete.
// - with combine clear, one compare trigger in the set is enough to set the flag.
// - with combine set, every compare trigger of the set is needed to set the flag.
// - the combine selection applies only while the depth field is above zero.
// - in fifo mode without scan results come out of the high/low pair in queued channel order.
module afc_fifo_ctrl (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq,
  output afc_pkg::afc_conv_req_t      conv_req,
  input  wire afc_pkg::afc_conv_rsp_t conv_rsp
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [3:0] f_level(input logic [2:0] depth);
    f_level = (depth == 3'h0) ? 4'h1 : {1'b0, depth} + 4'h1;
  endfunction

  function automatic logic f_mapped(input logic [7:0] addr);
    f_mapped = (addr == afc_pkg::OFF_CTRL) || (addr == afc_pkg::OFF_CHAN) ||
               (addr == afc_pkg::OFF_RES_HI) || (addr == afc_pkg::OFF_RES_LO) ||
               (addr == afc_pkg::OFF_IRQ_STAT) || (addr == afc_pkg::OFF_IRQ_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  afc_pkg::afc_ctrl_t  ctrl;
  afc_pkg::afc_ctrl_t  next_ctrl;
  afc_pkg::afc_sc1_t   sc1;
  afc_pkg::afc_sc1_t   next_sc1;
  afc_pkg::afc_state_t st;
  afc_pkg::afc_state_t next_st;
  logic                conversion_complete_flag;
  logic                next_conversion_complete_flag;
  logic [4:0]          chq       [afc_pkg::MAX_LEVELS];
  logic [4:0]          next_chq  [afc_pkg::MAX_LEVELS];
  logic [11:0]         res       [afc_pkg::MAX_LEVELS];
  logic [11:0]         next_res  [afc_pkg::MAX_LEVELS];
  logic [3:0]          ch_cnt;
  logic [3:0]          next_ch_cnt;
  logic [3:0]          res_cnt;
  logic [3:0]          next_res_cnt;
  logic [2:0]          rd_ptr;
  logic [2:0]          next_rd_ptr;
  logic [2:0]          wr_ptr;
  logic [2:0]          next_wr_ptr;
  logic [3:0]          idx;
  logic [3:0]          next_idx;
  logic                any_hit;
  logic                next_any_hit;
  logic                all_hit;
  logic                next_all_hit;
  logic [1:0]          irq_stat;
  logic [1:0]          next_irq_stat;
  logic [1:0]          irq_mask;
  logic [1:0]          next_irq_mask;
  logic [31:0]         next_prdata;
  logic                next_irq;
  afc_pkg::afc_conv_req_t next_conv_req;

  // combinational scratch
  logic                wr_acc;
  logic                rd_acc;
  logic                fifo_on;
  logic [3:0]          level;
  logic                set_done;
  logic                set_ok;
  logic                hit_any;
  logic                hit_all;
  logic [11:0]         head;
  logic [1:0]          ev;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~f_mapped(paddr);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    wr_acc        = psel & penable & pwrite & f_mapped(paddr);
    rd_acc        = psel & penable & ~pwrite & f_mapped(paddr);
    // depth zero leaves the fifo off
    fifo_on       = (ctrl.depth != 3'h0);
    level         = f_level(ctrl.depth);
    head          = res[rd_ptr];
    set_done      = 1'b0;
    set_ok        = 1'b0;
    hit_any       = any_hit;
    hit_all       = all_hit;
    ev            = 2'h0;
    next_ctrl     = ctrl;
    next_sc1      = sc1;
    next_st       = st;
    next_conversion_complete_flag     = conversion_complete_flag;
    next_chq      = chq;
    next_res      = res;
    next_ch_cnt   = ch_cnt;
    next_res_cnt  = res_cnt;
    next_rd_ptr   = rd_ptr;
    next_wr_ptr   = wr_ptr;
    next_idx      = idx;
    next_any_hit  = any_hit;
    next_all_hit  = all_hit;
    next_irq_mask = irq_mask;
    next_conv_req = '0;
    next_conv_req.chan = conv_req.chan;

    // result pop on the low half
    if (rd_acc && paddr == afc_pkg::OFF_RES_LO) begin
      if (fifo_on) begin
        if (res_cnt != 4'h0) begin
          next_rd_ptr  = rd_ptr + 3'h1;
          next_res_cnt = res_cnt - 4'h1;
          if (res_cnt == 4'h1) begin
            next_conversion_complete_flag = 1'b0;
          end
        end
      end else begin
        next_conversion_complete_flag = 1'b0;
      end
    end

    // control register write reconfigures and flushes
    if (wr_acc && paddr == afc_pkg::OFF_CTRL) begin
      next_ctrl.depth = pwdata[afc_pkg::DEPTH_LSB +: 3];
      next_ctrl.cmb   = pwdata[afc_pkg::CMB_BIT];
      next_ctrl.scan  = pwdata[afc_pkg::SCAN_BIT];
      next_st         = afc_pkg::ST_IDLE;
      next_ch_cnt     = 4'h0;
      next_res_cnt    = 4'h0;
      next_rd_ptr     = 3'h0;
      next_wr_ptr     = 3'h0;
      next_conversion_complete_flag       = 1'b0;
    end

    if (wr_acc && paddr == afc_pkg::OFF_CHAN) begin
      next_sc1.cont   = pwdata[afc_pkg::CONT_BIT];
      next_sc1.cmp_en = pwdata[afc_pkg::CMPEN_BIT];
      next_sc1.chan   = pwdata[afc_pkg::CHAN_LSB +: 5];
      next_conversion_complete_flag       = 1'b0;
      if (pwdata[afc_pkg::CHAN_LSB +: 5] == afc_pkg::CHAN_OFF) begin
        // all-ones channel stops the converter
        next_st      = afc_pkg::ST_IDLE;
        next_ch_cnt  = 4'h0;
      end else if (!fifo_on) begin
        next_chq[0]  = pwdata[afc_pkg::CHAN_LSB +: 5];
        next_ch_cnt  = 4'h1;
        next_res_cnt = 4'h0;
        next_rd_ptr  = 3'h0;
        next_wr_ptr  = 3'h0;
        next_idx     = 4'h0;
        next_any_hit = 1'b0;
        next_all_hit = 1'b1;
        next_st      = afc_pkg::ST_START;
      end else if ((st == afc_pkg::ST_IDLE || st == afc_pkg::ST_FILL) &&
                   ch_cnt < level) begin
        next_chq[ch_cnt[2:0]] = pwdata[afc_pkg::CHAN_LSB +: 5];
        next_ch_cnt  = ch_cnt + 4'h1;
        next_st      = afc_pkg::ST_FILL;
        if (ch_cnt == 4'h0) begin
          next_res_cnt = 4'h0;
          next_rd_ptr  = 3'h0;
          next_wr_ptr  = 3'h0;
        end
      end else begin
        // push refused while a set is queued or running
        ev[afc_pkg::IRQ_OVF] = 1'b1;
      end
    end

    if (wr_acc && paddr == afc_pkg::OFF_IRQ_MASK) begin
      next_irq_mask = pwdata[1:0];
    end

    unique case (st)
      afc_pkg::ST_IDLE: begin
      end
      afc_pkg::ST_FILL: begin
        // wait for a full channel fifo
        if (next_ch_cnt == level && next_st == afc_pkg::ST_FILL) begin
          next_st      = afc_pkg::ST_START;
          next_idx     = 4'h0;
          next_any_hit = 1'b0;
          next_all_hit = 1'b1;
        end
      end
      afc_pkg::ST_START: begin
        if (next_st == afc_pkg::ST_START) begin
          next_conv_req.start = 1'b1;
          // scan always takes the first queued channel
          next_conv_req.chan  = (ctrl.scan && fifo_on) ? chq[0] : chq[idx[2:0]];
          next_st             = afc_pkg::ST_WAIT;
        end
      end
      afc_pkg::ST_WAIT: begin
        if (conv_rsp.done && next_st == afc_pkg::ST_WAIT) begin
          if (res_cnt < 4'(afc_pkg::MAX_LEVELS)) begin
            next_res[wr_ptr] = conv_rsp.result;
            next_wr_ptr      = wr_ptr + 3'h1;
            next_res_cnt     = next_res_cnt + 4'h1;
          end
          hit_any      = any_hit | conv_rsp.cmp_hit;
          hit_all      = all_hit & conv_rsp.cmp_hit;
          next_any_hit = hit_any;
          next_all_hit = hit_all;
          // complete only after the whole set
          set_done     = (idx + 4'h1 == level);
          if (!set_done) begin
            next_idx = idx + 4'h1;
            next_st  = afc_pkg::ST_START;
          end else begin
            if (!sc1.cmp_en) begin
              set_ok = 1'b1;
            end else if (fifo_on) begin
              // combine only with the fifo on
              set_ok = ctrl.cmb ? hit_all : hit_any;
            end else begin
              set_ok = conv_rsp.cmp_hit;
            end
            if (set_ok) begin
              next_conversion_complete_flag = 1'b1;
              ev[afc_pkg::IRQ_CONVERSION_COMPLETE_FLAG] = 1'b1;
            end
            if (sc1.cont) begin
              // restart from the first queued channel once complete
              next_idx     = 4'h0;
              next_any_hit = 1'b0;
              next_all_hit = 1'b1;
              next_st      = afc_pkg::ST_START;
              // each restart refills the result store from its start
              next_res_cnt = 4'h0;
              next_rd_ptr  = 3'h0;
              next_wr_ptr  = 3'h0;
            end else begin
              next_st = afc_pkg::ST_IDLE;
              if (fifo_on) begin
                next_ch_cnt = 4'h0;
              end
            end
          end
        end
      end
    endcase

    // status read clears; a new event wins
    next_irq_stat = irq_stat;
    if (rd_acc && paddr == afc_pkg::OFF_IRQ_STAT) begin
      next_irq_stat = 2'h0;
    end
    next_irq_stat = next_irq_stat | ev;
    next_irq      = |(next_irq_stat & next_irq_mask);

    // read data latched in the setup phase
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = 32'h0;
      unique case (paddr)
        afc_pkg::OFF_CTRL: begin
          next_prdata[afc_pkg::DEPTH_LSB +: 3] = ctrl.depth;
          next_prdata[afc_pkg::CMB_BIT]        = ctrl.cmb;
          next_prdata[afc_pkg::SCAN_BIT]       = ctrl.scan;
        end
        afc_pkg::OFF_CHAN: begin
          next_prdata[afc_pkg::CHAN_LSB +: 5] = sc1.chan;
          next_prdata[afc_pkg::CONT_BIT]      = sc1.cont;
          next_prdata[afc_pkg::CMPEN_BIT]     = sc1.cmp_en;
          next_prdata[afc_pkg::CONVERSION_COMPLETE_FLAG_BIT]      = conversion_complete_flag;
        end
        afc_pkg::OFF_RES_HI: begin
          next_prdata[3:0] = head[afc_pkg::RES_HI_LSB +: 4];
        end
        afc_pkg::OFF_RES_LO: begin
          next_prdata[7:0] = head[7:0];
        end
        afc_pkg::OFF_IRQ_STAT: begin
          next_prdata[1:0] = irq_stat;
        end
        afc_pkg::OFF_IRQ_MASK: begin
          next_prdata[1:0] = irq_mask;
        end
        default: begin
          next_prdata = 32'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl       <= '0;
      ctrl.depth <= afc_pkg::DEPTH_RST;
      sc1        <= '0;
      sc1.chan   <= afc_pkg::CHAN_OFF;
      st         <= afc_pkg::ST_IDLE;
      conversion_complete_flag       <= 1'b0;
      chq        <= '{default: 5'h0};
      res        <= '{default: 12'h0};
      ch_cnt     <= 4'h0;
      res_cnt    <= 4'h0;
      rd_ptr     <= 3'h0;
      wr_ptr     <= 3'h0;
      idx        <= 4'h0;
      any_hit    <= 1'b0;
      all_hit    <= 1'b1;
      irq_stat   <= 2'h0;
      irq_mask   <= afc_pkg::IRQ_MASK_RST;
      prdata     <= 32'h0;
      irq        <= 1'b0;
      conv_req   <= '0;
    end else begin
      ctrl       <= next_ctrl;
      sc1        <= next_sc1;
      st         <= next_st;
      conversion_complete_flag       <= next_conversion_complete_flag;
      chq        <= next_chq;
      res        <= next_res;
      ch_cnt     <= next_ch_cnt;
      res_cnt    <= next_res_cnt;
      rd_ptr     <= next_rd_ptr;
      wr_ptr     <= next_wr_ptr;
      idx        <= next_idx;
      any_hit    <= next_any_hit;
      all_hit    <= next_all_hit;
      irq_stat   <= next_irq_stat;
      irq_mask   <= next_irq_mask;
      prdata     <= next_prdata;
      irq        <= next_irq;
      conv_req   <= next_conv_req;
    end
  end

endmodule
`default_nettype wire

// ### bench/afc_fifo_ctrl_monitor.sv
// assertion checker for the adc fifo control block
`timescale 1ns/10ps
`default_nettype none
module afc_monitor (
  input wire logic                   core_clk,
  input wire logic                   sys_rst,
  input wire logic [7:0]             paddr,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   irq,
  input wire afc_pkg::afc_conv_req_t conv_req,
  input wire afc_pkg::afc_conv_rsp_t conv_rsp
);
  logic       wr;
  logic       mp;
  logic [4:0] ctl, next_ctl;
  logic [1:0] msk, next_msk;
  logic [3:0] cnt, next_cnt;
  assign wr = psel && penable && pwrite;
  assign mp = paddr[1:0] == 2'h0 && paddr <= afc_pkg::OFF_IRQ_MASK;
  // shadow of control, mask and pushes since the last flush
  always_comb begin
    next_ctl = ctl;
    next_msk = msk;
    next_cnt = cnt;
    if (wr && paddr == afc_pkg::OFF_CTRL) begin
      next_ctl = {pwdata[6:5], pwdata[2:0]};
      next_cnt = 4'h0;
    end
    if (wr && paddr == afc_pkg::OFF_IRQ_MASK)
      next_msk = pwdata[1:0];
    if (wr && paddr == afc_pkg::OFF_CHAN)
      next_cnt = (pwdata[4:0] == 5'h1f) ? 4'h0 : cnt + {3'h0, cnt != 4'hf};
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctl <= 5'h0;
      msk <= 2'h0;
      cnt <= 4'h0;
    end else begin
      ctl <= next_ctl;
      msk <= next_msk;
      cnt <= next_cnt;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd_ctrl;
    psel && penable && !pwrite && paddr == afc_pkg::OFF_CTRL;
  endsequence
  sequence s_single_go;
    wr && paddr == afc_pkg::OFF_CHAN && ctl[2:0] == 3'h0 && pwdata[4:0] != 5'h1f;
  endsequence
  a_rsvd_bits_zero:
    assert property (s_rd_ctrl |-> prdata[7] == 1'b0 && prdata[4:3] == 2'h0)
    else $error("reserved control bits not zero");
  a_ctrl_readback:
    assert property (s_rd_ctrl |-> {prdata[6:5], prdata[2:0]} == ctl)
    else $error("control readback differs");
  a_single_start:
    assert property (s_single_go |-> ##[1:2] conv_req.start)
    else $error("single conversion not started");
  a_fill_no_start:
    assert property (ctl[2:0] != 3'h0 && cnt <= {1'b0, ctl[2:0]} |-> !conv_req.start)
    else $error("start before queue full");
  a_start_pulse:
    assert property (conv_req.start |=> !conv_req.start)
    else $error("start longer than one cycle");
  a_chan_steady:
    assert property (!conv_req.start |-> $stable(conv_req.chan))
    else $error("channel moved without start");
  a_irq_masked:
    assert property (msk == 2'h0 && $past(msk) == 2'h0 |-> !irq)
    else $error("irq with all masked");
  a_unmapped_err:
    assert property (psel && penable |-> pslverr == !mp && (mp || pwrite || prdata == 32'h0))
    else $error("slave error wrong");
endmodule
bind afc_fifo_ctrl afc_monitor u_mon (.core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .conv_req(conv_req), .conv_rsp(conv_rsp));
`default_nettype wire

// ### bench/afc_conv_model.sv
// behavioural model of the converter core
`timescale 1ns/10ps
`default_nettype none
module afc_conv_model (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire afc_pkg::afc_conv_req_t conv_req,
  input  wire logic [2:0]             lat,
  input  wire logic [7:0]             hit_pat,
  output afc_pkg::afc_conv_rsp_t      conv_rsp
);
  logic [2:0] left;
  logic [4:0] ch;
  logic [6:0] seq;
  // result is {sequence, channel}; lines toggle outside done
  // paced by bus clock, two edges per conversion at least
  always @(posedge core_clk) begin
    if (sys_rst) begin
      left     <= 3'h0;
      seq      <= 7'h0;
      conv_rsp <= '0;
    end else if (!conv_req.start && left == 3'h1) begin
      left     <= 3'h0;
      seq      <= seq + 7'h1;
      conv_rsp <= {1'b1, seq, ch, hit_pat[seq[2:0]]};
    end else begin
      conv_rsp <= {1'b0, ~conv_rsp.result, ~conv_rsp.cmp_hit};
      if (conv_req.start) begin
        left <= lat;
        ch   <= conv_req.chan;
      end else if (left != 3'h0) begin
        left <= left - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/tb_afc_fifo_ctrl.sv
// self-checking testbench of the adc fifo control block
`timescale 1ns/10ps
`default_nettype none
module tb_afc_fifo_ctrl;
  logic                   core_clk, sys_rst, psel, penable, pwrite, err, sc;
  logic [7:0]             paddr, hit_pat;
  logic [31:0]            pwdata, rd, res;
  logic [2:0]             lat;
  logic [4:0]             q[9];
  wire logic [31:0]       prdata;
  wire logic              pready, pslverr, irq;
  afc_pkg::afc_conv_req_t conv_req;
  afc_pkg::afc_conv_rsp_t conv_rsp;
  int                     miscompares, comparisons, ndone, i, d, k, s;
  afc_fifo_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .conv_req(conv_req), .conv_rsp(conv_rsp));
  afc_conv_model u_core (.core_clk(core_clk), .sys_rst(sys_rst), .conv_req(conv_req),
    .lat(lat), .hit_pat(hit_pat), .conv_rsp(conv_rsp));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (conv_rsp.done === 1'b1) ndone <= ndone + 1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // one apb transfer then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic getres();
    apb(1'b0, afc_pkg::OFF_RES_HI, 32'h0);
    res = {20'h0, rd[3:0], 8'h0};
    apb(1'b0, afc_pkg::OFF_RES_LO, 32'h0);
    res[7:0] = rd[7:0];
  endtask
  task automatic wait_done(input int n);
    for (int t = 0; t < 400 && ndone < n; t++) @(posedge core_clk);
    if (ndone < n) miscompares++;
  endtask
  function automatic logic [4:0] rch();
    return 5'($urandom_range(0, 30));
  endfunction
  // combine run: control value, hits of the one or two conversions, expected flag
  task automatic cmb_run(input logic [5:0] c, input logic [1:0] h, input logic e);
    int b;
    b = ndone;
    lat <= 3'($urandom_range(1, 7));
    hit_pat <= b[0] ? {4{h[0], h[1]}} : {4{h}};
    apb(1'b1, afc_pkg::OFF_CTRL, {26'h0, c});
    for (int j = 0; j <= c[0]; j++) apb(1'b1, afc_pkg::OFF_CHAN, {25'h0, 2'h2, rch()});
    wait_done(b + 1 + c[0]);
    apb(1'b0, afc_pkg::OFF_CHAN, 32'h0);
    chk("combine flag", {31'h0, e}, {31'h0, rd[7]});
  endtask
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  initial begin
    void'($urandom(32'h26ccb280));
    {sys_rst, psel, penable, pwrite, paddr, pwdata, hit_pat} = {1'b1, 51'h0};
    lat = 3'h1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, afc_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, afc_pkg::OFF_CHAN, 32'h0);
    chk("chan reset", 32'h1f, rd);
    apb(1'b1, afc_pkg::OFF_CTRL, 32'hff);
    apb(1'b0, afc_pkg::OFF_CTRL, 32'h0);
    chk("ctrl rsvd", 32'h67, rd);
    apb(1'b1, 8'h18, 32'hff);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, afc_pkg::OFF_CTRL, 32'h0);
    for (k = 0; k < 4; k++) begin
      apb(1'b1, afc_pkg::OFF_IRQ_MASK, k & 1);
      q[0] = rch();
      s = ndone;
      apb(1'b1, afc_pkg::OFF_CHAN, {27'h0, q[0]});
      wait_done(s + 1);
      repeat (2) @(posedge core_clk);
      chk("irq", k & 1, {31'h0, irq});
      getres();
      chk("single res", {20'h0, 7'(s), q[0]}, res);
      apb(1'b0, afc_pkg::OFF_IRQ_STAT, 32'h0);
      chk("stat", 32'h1, rd);
    end
    for (d = 1; d < 8; d++) begin
      sc = 1'($urandom_range(0, 1));
      lat <= 3'($urandom_range(1, 7));
      apb(1'b1, afc_pkg::OFF_CTRL, {25'h0, sc, 3'h0, 3'(d)});
      s = ndone;
      for (i = 0; i <= d + 1; i++) begin
        q[i] = rch();
        apb(1'b1, afc_pkg::OFF_CHAN, {27'h0, q[i]});
      end
      for (i = 0; i < 100 && rd[7] !== 1'b1; i++) apb(1'b0, afc_pkg::OFF_CHAN, 32'h0);
      chk("set size", d + 1, ndone - s);
      for (i = 0; i <= d; i++) begin
        getres();
        chk("fifo res", {20'h0, 7'(s + i), sc ? q[0] : q[i]}, res);
      end
      apb(1'b0, afc_pkg::OFF_IRQ_STAT, 32'h0);
      chk("refused push", 32'h3, rd);
    end
    for (k = 0; k < 8; k++) cmb_run({k[2], 5'h1}, k[1:0], k[2] ? &k[1:0] : |k[1:0]);
    cmb_run(6'h20, 2'h0, 1'b0);
    cmb_run(6'h20, 2'h3, 1'b1);
    apb(1'b1, afc_pkg::OFF_CTRL, 32'h41);
    s = ndone;
    q[0] = rch();
    apb(1'b1, afc_pkg::OFF_CHAN, {27'h1, q[0]});
    apb(1'b1, afc_pkg::OFF_CHAN, {27'h1, rch()});
    wait_done(s + 2);
    for (i = 0; i < 8 && conv_req.start !== 1'b1; i++) @(posedge core_clk);
    chk("restart", {27'h1, q[0]}, {26'h0, i < 8, conv_req.chan});
    apb(1'b1, afc_pkg::OFF_CHAN, 32'h1f);
    summarize();
  end
endmodule
`default_nettype wire
